//--- verilog/sbc_pkg.sv
package sbc_pkg;
	// Frame layout
	localparam int         FRAME_BITS = 16;
	localparam logic [4:0] CNT_ZERO   = 5'h00;
	localparam logic [4:0] CNT_FULL   = 5'h10;
	localparam logic [4:0] CNT_OVER   = 5'h11;
	localparam int         RW_BIT     = 7;
	localparam int         DATA_LSB   = 8;
	localparam int         DATA_MSB   = 15;
	// Address ranges
	localparam logic [6:0] CTRL_LAST  = 7'h1E;
	localparam logic [6:0] STAT_FIRST = 7'h40;
	localparam logic [6:0] STAT_LAST  = 7'h7E;
	// Status registers
	localparam logic [6:0] ADR_SUP2   = 7'h40;
	localparam logic [6:0] ADR_SUP1   = 7'h41;
	localparam logic [6:0] ADR_THERM  = 7'h42;
	localparam logic [6:0] ADR_DEV    = 7'h43;
	localparam logic [6:0] ADR_BUSF   = 7'h44;
	localparam logic [6:0] ADR_WAKE1  = 7'h46;
	localparam logic [6:0] ADR_WAKE2  = 7'h47;
	localparam logic [6:0] ADR_WKLVL  = 7'h48;
	localparam logic [6:0] ADR_OVL    = 7'h54;
	localparam logic [6:0] ADR_OPEN   = 7'h55;
	localparam logic [6:0] ADR_SWKST  = 7'h70;
	localparam logic [6:0] ADR_ECNT   = 7'h71;
	localparam logic [6:0] ADR_CDR1   = 7'h72;
	localparam logic [6:0] ADR_CDR2   = 7'h73;
	localparam logic [6:0] ADR_OSCH   = 7'h78;
	localparam logic [6:0] ADR_OSCL   = 7'h79;
	localparam logic [6:0] ADR_FAM    = 7'h7E;
	// Summary field order, bit 0 first
	localparam logic [6:0] SIF_ADR [8] = '{ADR_SUP1, ADR_THERM, ADR_DEV,
		ADR_BUSF, ADR_WAKE1, ADR_SUP2, ADR_OVL, ADR_OPEN};
	localparam int         SIF_WAKE   = 4;
	// Arbitrary identity value
	localparam logic [7:0] FAM_ID     = 8'h5A;
	// Control registers and fields
	localparam logic [6:0] ADR_MODE   = 7'h01;
	localparam logic [6:0] ADR_CAN    = 7'h04;
	localparam logic [6:0] ADR_HS1    = 7'h14;
	localparam logic [6:0] ADR_HS2    = 7'h15;
	localparam int         MODE_LSB   = 0;
	localparam int         MODE_MSB   = 2;
	localparam int         AUX_LSB    = 3;
	localparam int         AUX_MSB    = 4;
	localparam int         CAN_LSB    = 0;
	localparam int         CAN_MSB    = 2;
	localparam logic [2:0] CAN_OFF    = 3'h0;
	localparam logic [2:0] CAN_WAKE   = 3'h1;
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] STAT_RST   = 8'h00;

	typedef enum logic [5:0] {
		MODE_INIT     = 6'h01,
		MODE_NORMAL   = 6'h02,
		MODE_STOP     = 6'h04,
		MODE_SLEEP    = 6'h08,
		MODE_RESTART  = 6'h10,
		MODE_FAILSAFE = 6'h20
	} sbc_mode_e;

	typedef struct packed {
		logic [7:0][7:0] sif_set;
		logic [7:0]      wake2_set;
		logic [7:0]      wake_level;
		logic [7:0]      hs_trip;
	} sbc_evt_s;

	typedef struct packed {
		logic [2:0] mode_req;
		logic [1:0] aux_cfg;
		logic [2:0] can_cfg;
		logic [7:0] hs_cfg_1;
		logic [7:0] hs_cfg_2;
	} sbc_ctl_s;
endpackage

//--- verilog/sbc_spi_regs.sv
module sbc_spi_regs
	import sbc_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst_n,
	input  wire logic      spi_clk,
	input  wire logic      chip_select_low,
	input  wire logic      serial_in,
	input  wire sbc_mode_e mode_in,
	input  wire sbc_evt_s  evt,
	output logic           serial_out,
	output logic           serial_out_oe_n,
	output logic           spi_err,
	output sbc_ctl_s       ctl
);
	function automatic logic is_ctrl(input logic [6:0] a);
		return a <= CTRL_LAST;
	endfunction

	function automatic logic is_stat(input logic [6:0] a);
		return (a >= STAT_FIRST) && (a <= STAT_LAST);
	endfunction

	function automatic logic is_hs(input logic [6:0] a);
		return (a == ADR_HS1) || (a == ADR_HS2);
	endfunction

	function automatic logic is_fixed(input logic [6:0] a);
		case (a)
			ADR_WKLVL, ADR_FAM, ADR_OSCH, ADR_OSCL,
			ADR_SWKST, ADR_ECNT, ADR_CDR1, ADR_CDR2: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] sif_of(input logic [7:0] s [64]);
		logic [7:0] f;
		f = 8'h00;
		for (int i = 0; i < 8; i++)
			f[i] = |s[SIF_ADR[i][5:0]];
		f[SIF_WAKE] = f[SIF_WAKE] | (|s[ADR_WAKE2[5:0]]);
		return f;
	endfunction

	function automatic logic [2:0] mode_code(input sbc_mode_e m);
		case (m)
			MODE_NORMAL:   return 3'h0;
			MODE_SLEEP:    return 3'h1;
			MODE_STOP:     return 3'h2;
			MODE_RESTART:  return 3'h3;
			MODE_INIT:     return 3'h4;
			MODE_FAILSAFE: return 3'h5;
			default:       return 3'h7;
		endcase
	endfunction

	logic [7:0] ctrl_ff     [32];
	logic [7:0] nxt_ctrl    [32];
	logic [7:0] stat_ff     [64];
	logic [7:0] nxt_stat    [64];
	logic [7:0] shd_ctrl_ff [32];
	logic [7:0] shd_stat_ff [64];
	logic       cs_s1_ff;
	logic       cs_s2_ff;
	logic       cs_prev_ff;
	logic       clr_ff;
	logic       err_ff;
	sbc_mode_e  mode_prev_ff;
	logic [15:0] rx_ff;
	logic [4:0] cnt_ff;
	logic       out_ff;
	logic       rise_ff;

	// Frame decode, system side
	wire        frame_end  = cs_s2_ff & ~cs_prev_ff;
	wire [6:0]  f_adr      = rx_ff[6:0];
	wire        f_wr       = rx_ff[RW_BIT];
	wire [7:0]  f_dat      = rx_ff[DATA_MSB:DATA_LSB];
	wire        in_restart = (mode_in == MODE_RESTART);
	wire        in_normal  = (mode_in == MODE_NORMAL);
	wire        cnt_bad    = (cnt_ff != CNT_ZERO) && (cnt_ff != CNT_FULL);
	wire        frame_ok   = frame_end & (cnt_ff == CNT_FULL)
		& ~in_restart;
	wire        do_wr      = frame_ok & f_wr & is_ctrl(f_adr)
		& (~is_hs(f_adr) | in_normal);
	wire        do_clr     = frame_ok & f_wr & is_stat(f_adr)
		& ~is_fixed(f_adr);
	wire        mode_chg   = (mode_in != mode_prev_ff);
	wire [2:0]  can_now    = ctrl_ff[ADR_CAN[4:0]][CAN_MSB:CAN_LSB];

	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (do_wr)
			nxt_ctrl[f_adr[4:0]] = f_dat;
		// A tripped switch is switched off; no wake is raised here
		nxt_ctrl[ADR_HS1[4:0]] = nxt_ctrl[ADR_HS1[4:0]] & ~evt.hs_trip;
		// Status bytes are never touched on mode change
		if (mode_chg)
		begin
			nxt_ctrl[ADR_MODE[4:0]][MODE_MSB:MODE_LSB] =
				mode_code(mode_in);
			if ((mode_in == MODE_SLEEP) && (can_now != CAN_OFF)
				&& (can_now != CAN_WAKE))
				nxt_ctrl[ADR_CAN[4:0]][CAN_MSB:CAN_LSB] = CAN_WAKE;
			if (in_restart)
			begin
				nxt_ctrl[ADR_HS1[4:0]] = CTRL_RST;
				nxt_ctrl[ADR_HS2[4:0]] = CTRL_RST;
				nxt_ctrl[ADR_MODE[4:0]][AUX_MSB:AUX_LSB] = 2'h0;
			end
		end
	end

	always_comb
	begin
		nxt_stat = stat_ff;
		if (do_clr)
			nxt_stat[f_adr[5:0]] = STAT_RST;
		// Set after clear, so an event in the clear cycle survives
		for (int i = 0; i < 8; i++)
			nxt_stat[SIF_ADR[i][5:0]] =
				nxt_stat[SIF_ADR[i][5:0]] | evt.sif_set[i];
		nxt_stat[ADR_WAKE2[5:0]] = nxt_stat[ADR_WAKE2[5:0]] | evt.wake2_set;
		nxt_stat[ADR_WKLVL[5:0]] = evt.wake_level;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_s1_ff     <= 1'b1;
			cs_s2_ff     <= 1'b1;
			cs_prev_ff   <= 1'b1;
			clr_ff       <= 1'b1;
			err_ff       <= 1'b0;
			mode_prev_ff <= MODE_INIT;
		end
		else
		begin
			cs_s1_ff     <= chip_select_low;
			cs_s2_ff     <= cs_s1_ff;
			cs_prev_ff   <= cs_s2_ff;
			clr_ff       <= cs_s2_ff & cs_prev_ff;
			mode_prev_ff <= mode_in;
			if (frame_end)
				err_ff <= cnt_bad | in_restart;
		end
	end

	// Shadow is frozen while selected so the link reads stable bytes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 32; i++)
			begin
				ctrl_ff[i]     <= CTRL_RST;
				shd_ctrl_ff[i] <= CTRL_RST;
			end
			for (int i = 0; i < 64; i++)
			begin
				stat_ff[i]     <= STAT_RST;
				shd_stat_ff[i] <= STAT_RST;
			end
			// Identity byte is the only nonzero status after reset
			stat_ff[ADR_FAM[5:0]] <= FAM_ID;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
			stat_ff <= nxt_stat;
			if (cs_s2_ff)
			begin
				shd_ctrl_ff <= ctrl_ff;
				shd_stat_ff <= stat_ff;
			end
		end
	end

	// Link side; counter is held clear by the system side between frames
	wire [7:0]  sif_shd = sif_of(shd_stat_ff);
	wire [6:0]  rd_adr  = rx_ff[6:0];
	wire [7:0]  rd_byte = is_ctrl(rd_adr) ? shd_ctrl_ff[rd_adr[4:0]]
		: is_stat(rd_adr) ? shd_stat_ff[rd_adr[5:0]] : 8'h00;
	wire [15:0] tx_word = {rd_byte, sif_shd};
	wire        tx_bit  = in_restart ? 1'b1
		: (cnt_ff < CNT_FULL) ? tx_word[cnt_ff[3:0]] : 1'b0;

	always_ff @(negedge spi_clk or posedge clr_ff)
	begin
		if (clr_ff)
			cnt_ff <= CNT_ZERO;
		else if (cnt_ff != CNT_OVER)
			cnt_ff <= cnt_ff + 5'h01;
	end

	always_ff @(negedge spi_clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_ff <= 16'h0000;
		else if (cnt_ff < CNT_FULL)
			rx_ff[cnt_ff[3:0]] <= serial_in;
	end

	always_ff @(posedge spi_clk or posedge clr_ff)
	begin
		if (clr_ff)
		begin
			out_ff  <= 1'b0;
			rise_ff <= 1'b0;
		end
		else
		begin
			out_ff  <= tx_bit;
			rise_ff <= 1'b1;
		end
	end

	// Error shows before the first rising edge of the next frame
	assign serial_out      = rise_ff ? out_ff : err_ff;
	assign serial_out_oe_n = chip_select_low;
	assign spi_err         = err_ff;
	assign ctl.mode_req    = ctrl_ff[ADR_MODE[4:0]][MODE_MSB:MODE_LSB];
	assign ctl.aux_cfg     = ctrl_ff[ADR_MODE[4:0]][AUX_MSB:AUX_LSB];
	assign ctl.can_cfg     = can_now;
	assign ctl.hs_cfg_1    = ctrl_ff[ADR_HS1[4:0]];
	assign ctl.hs_cfg_2    = ctrl_ff[ADR_HS2[4:0]];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_ctrl_write;
		do_wr && !mode_chg && !is_hs(f_adr);
	endsequence

	sequence s_ctrl_seen;
		ctrl_ff[f_adr[4:0]] == f_dat;
	endsequence

	property p_ctrl_wr;
		s_ctrl_write |=> s_ctrl_seen;
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr)
		else $error("control write not stored");

	property p_clear;
		do_clr && (f_adr == ADR_THERM) && (evt.sif_set[1] == 8'h00)
			|=> stat_ff[ADR_THERM[5:0]] == STAT_RST;
	endproperty
	a_clear: assert property (p_clear)
		else $error("status clear failed");

	property p_sticky;
		!(do_clr && (f_adr == ADR_SUP1)) |=>
			((stat_ff[ADR_SUP1[5:0]] & $past(stat_ff[ADR_SUP1[5:0]]))
			== $past(stat_ff[ADR_SUP1[5:0]]));
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("status bit dropped without clear");

	property p_restart_ign;
		frame_end && in_restart && !mode_chg
			|=> err_ff && $stable(ctrl_ff[ADR_CAN[4:0]]);
	endproperty
	a_restart_ign: assert property (p_restart_ign)
		else $error("frame acted on in restart");

	property p_bad_cnt;
		frame_end && cnt_bad && !mode_chg && (evt.hs_trip == 8'h00)
			|=> err_ff && $stable(ctrl_ff[f_adr[4:0]]);
	endproperty
	a_bad_cnt: assert property (p_bad_cnt)
		else $error("bad clock count not flagged");

	property p_sif_set;
		cs_s2_ff && (|stat_ff[ADR_WAKE2[5:0]]) |=> sif_shd[SIF_WAKE];
	endproperty
	a_sif_set: assert property (p_sif_set)
		else $error("wake summary bit missing");

	property p_sif_clr;
		cs_s2_ff && (stat_ff[ADR_SUP1[5:0]] == STAT_RST) |=> !sif_shd[0];
	endproperty
	a_sif_clr: assert property (p_sif_clr)
		else $error("summary bit stuck");

	property p_fixed;
		frame_ok && f_wr && (f_adr == ADR_FAM)
			|=> stat_ff[ADR_FAM[5:0]] == FAM_ID;
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed register cleared");

	property p_stop_can;
		mode_chg && (mode_in == MODE_STOP) && !do_wr |=> $stable(can_now);
	endproperty
	a_stop_can: assert property (p_stop_can)
		else $error("CAN bits changed on stop entry");

	property p_sleep_can;
		mode_chg && (mode_in == MODE_SLEEP) && (can_now > CAN_WAKE)
			&& !do_wr |=> can_now == CAN_WAKE;
	endproperty
	a_sleep_can: assert property (p_sleep_can)
		else $error("CAN bits not moved on sleep entry");

	property p_restart_hs;
		mode_chg && in_restart |=> (ctl.hs_cfg_1 == CTRL_RST)
			&& (ctl.hs_cfg_2 == CTRL_RST) && (ctl.aux_cfg == 2'h0);
	endproperty
	a_restart_hs: assert property (p_restart_hs)
		else $error("switch config kept in restart");

	property p_mode_bits;
		mode_chg |=> ctl.mode_req == mode_code($past(mode_in));
	endproperty
	a_mode_bits: assert property (p_mode_bits)
		else $error("mode bits not updated");

	property p_sif_rise;
		cs_s2_ff && (|stat_ff[ADR_SUP1[5:0]]) |=> sif_shd[0];
	endproperty
	a_sif_rise: assert property (p_sif_rise)
		else $error("summary bit not raised");

	property p_sif_wake_clr;
		cs_s2_ff && (stat_ff[ADR_WAKE1[5:0]] == STAT_RST)
			&& (stat_ff[ADR_WAKE2[5:0]] == STAT_RST)
			|=> !sif_shd[SIF_WAKE];
	endproperty
	a_sif_wake_clr: assert property (p_sif_wake_clr)
		else $error("wake summary bit stuck");

	property p_hs_lock;
		frame_ok && f_wr && is_hs(f_adr) && !in_normal && !mode_chg
			&& (evt.hs_trip == 8'h00) |=> $stable(ctrl_ff[f_adr[4:0]]);
	endproperty
	a_hs_lock: assert property (p_hs_lock)
		else $error("switch config written outside normal");

	// Diagnosis survives low-power entry unless the host clears it
	property p_lowpower_keep;
		mode_chg && ((mode_in == MODE_STOP) || (mode_in == MODE_SLEEP))
			&& !do_clr |=> ((stat_ff[ADR_OVL[5:0]]
			& $past(stat_ff[ADR_OVL[5:0]])) == $past(stat_ff[ADR_OVL[5:0]]));
	endproperty
	a_lowpower_keep: assert property (p_lowpower_keep)
		else $error("diagnosis lost on low-power entry");

	property p_err_ok;
		frame_end && !cnt_bad && !in_restart |=> !err_ff;
	endproperty
	a_err_ok: assert property (p_err_ok)
		else $error("error flag left set after good frame");
endmodule // sbc_spi_regs

//--- tb/sbc_host_model.sv
module sbc_host_model
(
	output logic      spi_clk,
	output logic      chip_select_low,
	output logic      serial_in,
	input  wire logic serial_out,
	input  wire logic serial_out_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;

	logic last_v = 1'b0;
	logic line_v;

	// Released line shows the inverse of the last driven bit
	always @(serial_out or serial_out_oe_n)
		if (!serial_out_oe_n)
			last_v = serial_out;
	assign line_v = serial_out_oe_n ? ~last_v : serial_out;

	initial
	begin
		spi_clk = 1'b0;
		chip_select_low = 1'b1;
		serial_in = 1'b0;
	end

	// Word is {data, rw, address}, sent bit 0 first
	task automatic xfer(input logic [15:0] cmd, input int n,
		output logic [15:0] rsp, output logic err);
		rsp = 16'h0000;
		chip_select_low = 1'b0;
		// Odd lead keeps link edges off the system clock edges
		#53;
		err = line_v;
		for (int k = 0; k < n; k++)
		begin
			#15 spi_clk = 1'b1;
			// Data moves mid-high, clear of the sampling fall
			#7 serial_in = cmd[k];
			rsp[k] = line_v;
			#8 spi_clk = 1'b0;
		end
		#40 chip_select_low = 1'b1;
		serial_in = ~serial_in;
		// Gap covers the link crossing and the update
		#100;
	endtask
endmodule // sbc_host_model

//--- tb/sbc_spi_register_access_tb.sv
module sbc_spi_register_access_tb
	import sbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk;
	logic        rst_n;
	sbc_mode_e   mode_in;
	sbc_evt_s    evt;
	logic        spi_clk;
	logic        chip_select_low;
	logic        serial_in;
	logic        serial_out;
	logic        serial_out_oe_n;
	logic        spi_err;
	sbc_ctl_s    ctl;
	int          mismatches;
	int          tests_run;
	logic [15:0] seed;
	logic [15:0] rsp;
	logic        err;
	logic [7:0]  stat_m [8];
	logic [7:0]  wake2_m;
	logic [7:0]  hs_m;

	sbc_spi_regs i_dut (.clk(clk), .rst_n(rst_n), .spi_clk(spi_clk),
		.chip_select_low(chip_select_low), .serial_in(serial_in),
		.mode_in(mode_in), .evt(evt), .serial_out(serial_out),
		.serial_out_oe_n(serial_out_oe_n), .spi_err(spi_err), .ctl(ctl));

	sbc_host_model i_host (.spi_clk(spi_clk),
		.chip_select_low(chip_select_low), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));

	always #5 clk = ~clk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Expected summary field from the status model
	function automatic logic [7:0] sif();
		for (int i = 0; i < 8; i++)
			sif[i] = (|stat_m[i]) | ((i == SIF_WAKE) & (|wake2_m));
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (mismatches == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic frame(input logic [6:0] a, input logic w,
		input logic [7:0] d);
		i_host.xfer({d, w, a}, 16, rsp, err);
	endtask

	task automatic set_mode(input sbc_mode_e m);
		@(negedge clk) mode_in = m;
		repeat (3) @(negedge clk);
	endtask

	initial
	begin
		#200000;
		mismatches++;
		end_sim();
	end

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		mode_in = MODE_NORMAL;
		evt = '0;
		mismatches = 0;
		tests_run = 0;
		seed = 16'h58F1;
		stat_m = '{default: 8'h00};
		wake2_m = 8'h00;
		hs_m = 8'h00;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		frame(ADR_FAM, 1'b0, 8'h00);
		check(rsp, {FAM_ID, 8'h00});
		check({15'h0000, err}, 16'h0000);
		// Set each summarised register, read it back while still set
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			stat_m[i] = seed[7:0] | 8'h01;
			@(negedge clk) evt.sif_set[i] = stat_m[i];
			@(negedge clk) evt.sif_set[i] = 8'h00;
			frame(SIF_ADR[i], 1'b0, 8'h00);
			check(rsp, {stat_m[i], sif()});
		end
		// Clear one at a time; the summary must drop in step
		for (int i = 0; i < 8; i++)
		begin
			frame(SIF_ADR[i], 1'b1, 8'h00);
			check(rsp, {stat_m[i], sif()});
			stat_m[i] = 8'h00;
		end
		frame(ADR_SUP1, 1'b0, 8'h00);
		check(rsp, 16'h0000);
		@(negedge clk) evt.wake2_set = 8'h80;
		evt.wake_level = 8'h3C;
		@(negedge clk) evt.wake2_set = 8'h00;
		wake2_m = 8'h80;
		frame(ADR_WAKE2, 1'b1, 8'h00);
		check(rsp, {8'h80, 8'h10});
		wake2_m = 8'h00;
		frame(ADR_WKLVL, 1'b1, 8'h00);
		check(rsp, {8'h3C, 8'h00});
		frame(ADR_WKLVL, 1'b0, 8'h00);
		check(rsp, {8'h3C, 8'h00});
		frame(ADR_FAM, 1'b1, 8'h00);
		frame(ADR_FAM, 1'b0, 8'h00);
		check(rsp, {FAM_ID, 8'h00});
		// Random switch settings; old byte shows during the write
		repeat (4)
		begin
			seed = lfsr(seed);
			frame(ADR_HS1, 1'b1, seed[7:0]);
			check(rsp, {hs_m, 8'h00});
			hs_m = seed[7:0];
			check({8'h00, ctl.hs_cfg_1}, {8'h00, hs_m});
			frame(ADR_HS1, 1'b0, ~hs_m);
			frame(ADR_HS1, 1'b0, 8'h00);
			check(rsp, {hs_m, 8'h00});
		end
		hs_m = hs_m | 8'h01;
		frame(ADR_HS1, 1'b1, hs_m);
		frame(ADR_HS2, 1'b1, 8'hC3);
		check({8'h00, ctl.hs_cfg_2}, 16'h00C3);
		frame(7'h30, 1'b1, 8'hFF);
		frame(7'h30, 1'b0, 8'h00);
		check(rsp, 16'h0000);
		frame(ADR_CAN, 1'b1, 8'h05);
		frame(ADR_MODE, 1'b1, 8'h18);
		check({14'h0000, ctl.aux_cfg}, 16'h0003);
		// Switch fault turns the tripped switch off
		@(negedge clk) evt.hs_trip = 8'h01;
		@(negedge clk) evt.hs_trip = 8'h00;
		hs_m = hs_m & 8'hFE;
		repeat (2) @(negedge clk);
		check({8'h00, ctl.hs_cfg_1}, {8'h00, hs_m});
		// Short frame must be discarded and flagged
		i_host.xfer({8'hFF, 1'b1, ADR_HS1}, 8, rsp, err);
		check({15'h0000, spi_err}, 16'h0001);
		frame(ADR_HS1, 1'b0, 8'h00);
		check(rsp, {hs_m, 8'h00});
		check({15'h0000, err}, 16'h0001);
		frame(ADR_HS1, 1'b0, 8'h00);
		check({15'h0000, err}, 16'h0000);
		check({15'h0000, serial_out_oe_n}, 16'h0001);
		// Overload diagnosis pending across stop entry
		stat_m[6] = 8'h24;
		@(negedge clk) evt.sif_set[6] = stat_m[6];
		@(negedge clk) evt.sif_set[6] = 8'h00;
		set_mode(MODE_STOP);
		check({10'h000, ctl.mode_req, ctl.can_cfg}, 16'h0015);
		frame(ADR_OVL, 1'b0, 8'h00);
		check(rsp, {stat_m[6], sif()});
		frame(ADR_HS1, 1'b1, 8'hFF);
		check({8'h00, ctl.hs_cfg_1}, {8'h00, hs_m});
		set_mode(MODE_NORMAL);
		set_mode(MODE_SLEEP);
		check({10'h000, ctl.mode_req, ctl.can_cfg}, 16'h0009);
		set_mode(MODE_RESTART);
		check({13'h0000, ctl.mode_req}, 16'h0003);
		check({ctl.hs_cfg_1, ctl.hs_cfg_2}, 16'h0000);
		check({14'h0000, ctl.aux_cfg}, 16'h0000);
		frame(ADR_CAN, 1'b1, 8'h00);
		check(rsp, 16'hFFFF);
		check({13'h0000, ctl.can_cfg}, 16'h0001);
		set_mode(MODE_NORMAL);
		frame(ADR_CAN, 1'b0, 8'h00);
		check({15'h0000, err}, 16'h0001);
		end_sim();
	end
endmodule // sbc_spi_register_access_tb
